// File: hw/lpea_pkg.sv
package lpea_pkg;

   // ****************************************
   // Opcodes
   // ****************************************
   // High nibble of a pointer load picks the addressing mode
   localparam logic [3:0] MODE_NIB_IMM = 4'hc;
   localparam logic [3:0] MODE_NIB_DIR = 4'hd;
   localparam logic [3:0] MODE_NIB_IDX = 4'he;
   localparam logic [3:0] MODE_NIB_EXT = 4'hf;
   // Low nibble of a pointer load picks the destination
   localparam logic [3:0] DEST_NIB_SP = 4'hf;
   localparam logic [3:0] DEST_NIB_X = 4'he;
   localparam logic [3:0] DEST_NIB_Y = 4'hd;
   localparam logic [7:0] STACK_POINTER_EA_LOAD_OP = 8'h1b;
   localparam logic [7:0] FIRST_INDEX_EA_LOAD_OP = 8'h1a;
   localparam logic [7:0] SECOND_INDEX_EA_LOAD_OP = 8'h19;

   // ****************************************
   // Cycle counts
   // ****************************************
   localparam logic [2:0] CYC_IMM = 3'h2;
   localparam logic [2:0] CYC_DIR_EXT = 3'h3;
   localparam logic [2:0] CYC_IDX = 3'h3;
   localparam logic [2:0] CYC_IDX16 = 3'h4;
   localparam logic [2:0] CYC_IND = 3'h6;
   localparam logic [2:0] CYC_LEA = 3'h2;

   // ****************************************
   // Index base selects and postbyte fields
   // ****************************************
   localparam logic [1:0] BASE_X = 2'h0;
   localparam logic [1:0] BASE_Y = 2'h1;
   localparam logic [1:0] BASE_SP = 2'h2;
   localparam logic [1:0] BASE_PC = 2'h3;
   localparam logic [2:0] PB_EXT_FORM = 3'h7;
   localparam logic [1:0] ACC_A = 2'h0;
   localparam logic [1:0] ACC_B = 2'h1;

   // ****************************************
   // Register port map and reset values
   // ****************************************
   localparam logic [2:0] REG_X = 3'h0;
   localparam logic [2:0] REG_Y = 3'h1;
   localparam logic [2:0] REG_SP = 3'h2;
   localparam logic [2:0] REG_CCR = 3'h3;
   localparam logic [2:0] REG_STATUS = 3'h4;
   localparam logic [15:0] PTR_RESET = 16'h0000;
   localparam logic [7:0] CCR_RESET = 8'hd0;
   localparam int CCR_N = 3;
   localparam int CCR_Z = 2;
   localparam int CCR_V = 1;

   typedef enum logic [1:0] {DST_X, DST_Y, DST_SP} lpea_dest_t;
   typedef enum logic [2:0] {
      CLS_SHORT, CLS_NINE, CLS_SIXTEEN, CLS_ACC, CLS_AUTO, CLS_IND16,
      CLS_INDD
   } lpea_cls_t;

   function automatic logic pb_is_indirect(input logic [7:0] pb);
      pb_is_indirect = (pb[7:5] == PB_EXT_FORM) && (pb[1:0] == 2'h3);
   endfunction : pb_is_indirect

   function automatic logic pb_is_long16(input logic [7:0] pb);
      pb_is_long16 = (pb[7:5] == PB_EXT_FORM) && (pb[2:0] == 3'h2);
   endfunction : pb_is_long16

endpackage : lpea_pkg

// File: hw/lpea_idx_if.sv
`timescale 1ns/100ps
`default_nettype none
interface lpea_idx_if;
   logic [7:0] postbyte;
   logic [15:0] extended_mode;
   logic [15:0] x;
   logic [15:0] y;
   logic [15:0] sp;
   logic [15:0] pc;
   logic [15:0] d;
   logic [15:0] ea;
   logic [15:0] base_new;
   logic [1:0] base_sel;
   logic auto_mod;
   lpea_pkg::lpea_cls_t cls;

   modport calc (
      input postbyte, extended_mode, x, y, sp, pc, d,
      output ea, base_new, base_sel, auto_mod, cls
   );
   modport user (
      output postbyte, extended_mode, x, y, sp, pc, d,
      input ea, base_new, base_sel, auto_mod, cls
   );
endinterface : lpea_idx_if
`default_nettype wire

// File: hw/lpea_idx_calc.sv
`timescale 1ns/100ps
`default_nettype none
module lpea_idx_calc (
   lpea_idx_if.calc bus
);
   logic [7:0] pb;
   logic ext_form;
   logic auto_form;
   logic pre_mod;
   logic [15:0] base;
   logic [15:0] off;
   logic [15:0] delta;
   logic [15:0] sum;

   assign pb = bus.postbyte;
   assign ext_form = (pb[7:5] == lpea_pkg::PB_EXT_FORM);
   assign auto_form = pb[5] && !ext_form;
   assign pre_mod = !pb[4];
   assign bus.base_sel = ext_form ? pb[4:3] : pb[7:6];

   assign base = (bus.base_sel == lpea_pkg::BASE_X) ? bus.x :
                 (bus.base_sel == lpea_pkg::BASE_Y) ? bus.y :
                 (bus.base_sel == lpea_pkg::BASE_SP) ? bus.sp : bus.pc;

   // Auto step: 0..7 mean +1..+8, 8..15 mean -8..-1
   assign delta = pb[3] ? {12'hfff, pb[3:0]} :
                  16'({12'h000, pb[3:0]} + 16'h0001);

   // ****************************************
   // Offset and class selection
   // ****************************************
   always_comb begin
      off = 16'h0000;
      bus.cls = lpea_pkg::CLS_SHORT;
      if (!pb[5]) begin
         off = {{11{pb[4]}}, pb[4:0]};
      end else if (auto_form) begin
         off = delta;
         bus.cls = lpea_pkg::CLS_AUTO;
      end else if (!pb[2] && !pb[1]) begin
         off = {{8{pb[0]}}, bus.extended_mode[7:0]};
         bus.cls = lpea_pkg::CLS_NINE;
      end else if (!pb[2]) begin
         off = bus.extended_mode;
         bus.cls = pb[0] ? lpea_pkg::CLS_IND16 : lpea_pkg::CLS_SIXTEEN;
      end else if (pb[1:0] == lpea_pkg::ACC_A) begin
         off = {8'h00, bus.d[15:8]};
         bus.cls = lpea_pkg::CLS_ACC;
      end else if (pb[1:0] == lpea_pkg::ACC_B) begin
         off = {8'h00, bus.d[7:0]};
         bus.cls = lpea_pkg::CLS_ACC;
      end else begin
         off = bus.d;
         bus.cls = pb[0] ? lpea_pkg::CLS_INDD : lpea_pkg::CLS_ACC;
      end
   end

   assign sum = 16'(base + off);
   assign bus.auto_mod = auto_form;
   assign bus.base_new = sum;
   // Pre form drives the stepped value, post form the old base
   assign bus.ea = (auto_form && !pre_mod) ? base : sum;
endmodule : lpea_idx_calc
`default_nettype wire

// File: hw/lpea_unit.sv
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
module lpea_unit (
   input wire logic clock,
   input wire logic rst,
   input wire logic start,
   input wire logic [7:0] opcode,
   input wire logic [7:0] postbyte,
   input wire logic [15:0] operand,
   input wire logic [15:0] pc_in,
   input wire logic [15:0] acc_d,
   output logic busy,
   output logic done,
   output logic illegal,
   output logic mem_rd,
   output logic mem_word,
   output logic [15:0] mem_addr,
   input wire logic [15:0] mem_rdata,
   output logic prog_fetch,
   output logic [15:0] prog_addr,
   input wire logic [2:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic [15:0] ptr_x,
   output logic [15:0] ptr_y,
   output logic [15:0] ptr_sp,
   output logic [7:0] condition_code_register
);

   typedef enum logic [2:0] {
      P_IDLE, P_WAIT, P_PTR_A, P_PTR_B, P_OP_A, P_OP_B, P_HOLD
   } lpea_phase_t;
   typedef enum logic [2:0] {
      PD_NONE, PD_PTR_W, PD_PTR_H, PD_PTR_L, PD_OP_W, PD_OP_H, PD_OP_L
   } lpea_pend_t;

   // ****************************************
   // Opcode decoding
   // ****************************************
   function automatic logic is_lea(input logic [7:0] op);
      is_lea = (op == lpea_pkg::STACK_POINTER_EA_LOAD_OP) ||
               (op == lpea_pkg::FIRST_INDEX_EA_LOAD_OP) ||
               (op == lpea_pkg::SECOND_INDEX_EA_LOAD_OP);
   endfunction : is_lea

   function automatic logic is_load(input logic [7:0] op);
      is_load = ((op[7:4] == lpea_pkg::MODE_NIB_IMM) ||
                 (op[7:4] == lpea_pkg::MODE_NIB_DIR) ||
                 (op[7:4] == lpea_pkg::MODE_NIB_IDX) ||
                 (op[7:4] == lpea_pkg::MODE_NIB_EXT)) &&
                ((op[3:0] == lpea_pkg::DEST_NIB_SP) ||
                 (op[3:0] == lpea_pkg::DEST_NIB_X) ||
                 (op[3:0] == lpea_pkg::DEST_NIB_Y));
   endfunction : is_load

   function automatic lpea_pkg::lpea_dest_t dest_of(input logic [7:0] op);
      if (op == lpea_pkg::STACK_POINTER_EA_LOAD_OP ||
          op[3:0] == lpea_pkg::DEST_NIB_SP) begin
         dest_of = lpea_pkg::DST_SP;
      end else if (op == lpea_pkg::FIRST_INDEX_EA_LOAD_OP ||
                   op[3:0] == lpea_pkg::DEST_NIB_X) begin
         dest_of = lpea_pkg::DST_X;
      end else begin
         dest_of = lpea_pkg::DST_Y;
      end
   endfunction : dest_of

   lpea_phase_t ph_reg;
   lpea_phase_t ph_next;
   lpea_pend_t pend_reg;
   lpea_pend_t pend_next;
   logic [2:0] cyc_reg;
   logic [7:0] op_reg;
   logic [7:0] pb_reg;
   logic [15:0] ext_reg;
   logic [15:0] ptr_reg;
   logic [15:0] data_reg;
   logic [15:0] addr_reg;
   logic [15:0] x_reg;
   logic [15:0] y_reg;
   logic [15:0] sp_reg;
   logic [7:0] ccr_reg;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;

   lpea_idx_if idx ();

   lpea_idx_calc u_calc (
      .bus(idx.calc)
   );

   assign idx.postbyte = pb_reg;
   assign idx.extended_mode = ext_reg;
   assign idx.x = x_reg;
   assign idx.y = y_reg;
   assign idx.sp = sp_reg;
   assign idx.pc = pc_in;
   assign idx.d = acc_d;

   // ****************************************
   // Start acceptance
   // ****************************************
   logic start_ok;
   logic in_lea;
   logic in_valid;
   logic accept;
   logic in_idx;
   lpea_phase_t first_ph;

   assign start_ok = start && (ph_reg == P_IDLE);
   assign in_lea = is_lea(opcode);
   // Indirect postbyte on an address load is refused outright
   assign in_valid = (in_lea && !lpea_pkg::pb_is_indirect(postbyte)) ||
                     is_load(opcode);
   assign accept = start_ok && in_valid;
   assign illegal = start_ok && !in_valid;
   assign in_idx = (opcode[7:4] == lpea_pkg::MODE_NIB_IDX);
   assign first_ph = (in_lea || opcode[7:4] == lpea_pkg::MODE_NIB_IMM) ?
                     P_HOLD :
                     (in_idx && (lpea_pkg::pb_is_indirect(postbyte) ||
                      lpea_pkg::pb_is_long16(postbyte))) ? P_WAIT : P_OP_A;

   // ****************************************
   // Instruction timing
   // ****************************************
   logic cur_lea;
   logic [3:0] cur_mode;
   logic cur_ind;
   logic [2:0] total;
   logic last;
   lpea_pkg::lpea_dest_t cur_dest;

   assign cur_lea = is_lea(op_reg);
   assign cur_mode = op_reg[7:4];
   assign cur_dest = dest_of(op_reg);
   assign cur_ind = (idx.cls == lpea_pkg::CLS_IND16) ||
                    (idx.cls == lpea_pkg::CLS_INDD);
   assign total = cur_lea ? lpea_pkg::CYC_LEA :
                  (cur_mode == lpea_pkg::MODE_NIB_IMM) ? lpea_pkg::CYC_IMM :
                  (cur_mode != lpea_pkg::MODE_NIB_IDX) ?
                     lpea_pkg::CYC_DIR_EXT :
                  cur_ind ? lpea_pkg::CYC_IND :
                  (idx.cls == lpea_pkg::CLS_SIXTEEN) ? lpea_pkg::CYC_IDX16 :
                  lpea_pkg::CYC_IDX;
   assign busy = (ph_reg != P_IDLE);
   assign last = busy && (cyc_reg == total);
   assign done = last;

   // ****************************************
   // Incoming data merge
   // ****************************************
   logic [15:0] ptr_fwd;
   logic [15:0] data_fwd;
   logic [15:0] op_addr;

   // Forwarding lets a read use data in the cycle it arrives
   assign ptr_fwd = (pend_reg == PD_PTR_W) ? mem_rdata :
                    (pend_reg == PD_PTR_H) ?
                       {mem_rdata[7:0], ptr_reg[7:0]} :
                    (pend_reg == PD_PTR_L) ?
                       {ptr_reg[15:8], mem_rdata[7:0]} : ptr_reg;
   assign data_fwd = (pend_reg == PD_OP_W) ? mem_rdata :
                     (pend_reg == PD_OP_H) ?
                        {mem_rdata[7:0], data_reg[7:0]} :
                     (pend_reg == PD_OP_L) ?
                        {data_reg[15:8], mem_rdata[7:0]} : data_reg;
   assign op_addr = (cur_mode == lpea_pkg::MODE_NIB_DIR) ?
                       {8'h00, ext_reg[7:0]} :
                    (cur_mode == lpea_pkg::MODE_NIB_EXT) ? ext_reg :
                    cur_ind ? ptr_fwd : idx.ea;

   // ****************************************
   // Memory request
   // ****************************************
   logic rd_ptr_a;
   logic rd_op_a;

   assign rd_ptr_a = (ph_reg == P_PTR_A);
   assign rd_op_a = (ph_reg == P_OP_A);
   assign mem_rd = rd_ptr_a || rd_op_a || (ph_reg == P_PTR_B) ||
                   (ph_reg == P_OP_B);
   assign mem_addr = rd_ptr_a ? idx.ea :
                     rd_op_a ? op_addr :
                     16'(addr_reg + 16'h0001);
   // Word access only when even; odd goes high byte then low
   assign mem_word = (rd_ptr_a || rd_op_a) && !mem_addr[0];

   always_comb begin
      ph_next = ph_reg;
      pend_next = PD_NONE;
      case (ph_reg)
         P_IDLE: begin
            if (accept) begin
               ph_next = first_ph;
            end
         end
         P_WAIT: begin
            ph_next = cur_ind ? P_PTR_A : P_OP_A;
         end
         P_PTR_A: begin
            pend_next = mem_word ? PD_PTR_W : PD_PTR_H;
            ph_next = mem_word ? P_OP_A : P_PTR_B;
         end
         P_PTR_B: begin
            pend_next = PD_PTR_L;
            ph_next = P_OP_A;
         end
         P_OP_A: begin
            pend_next = mem_word ? PD_OP_W : PD_OP_H;
            ph_next = mem_word ? P_HOLD : P_OP_B;
         end
         P_OP_B: begin
            pend_next = PD_OP_L;
            ph_next = P_HOLD;
         end
         default: begin
            if (last) begin
               ph_next = P_IDLE;
            end
         end
      endcase
   end

   // ****************************************
   // Program fetch
   // ****************************************
   logic short_lea;

   assign short_lea = cur_lea && (idx.cls == lpea_pkg::CLS_SHORT);
   assign prog_fetch = busy && (cur_lea || last);
   // Short form repeats the fetch at the same address
   assign prog_addr = (cur_lea && cyc_reg != 3'h1 && !short_lea) ?
                      16'(pc_in + 16'h0002) : pc_in;

   // ****************************************
   // Write back
   // ****************************************
   logic [15:0] result;
   logic load_done;
   logic base_step;
   logic wr_ok;
   logic [15:0] x_next;
   logic [15:0] y_next;
   logic [15:0] sp_next;
   logic [7:0] ccr_next;

   assign result = cur_lea ? idx.ea :
                   (cur_mode == lpea_pkg::MODE_NIB_IMM) ? ext_reg : data_fwd;
   assign load_done = last && !cur_lea;
   assign base_step = last && idx.auto_mod &&
                      (cur_lea || cur_mode == lpea_pkg::MODE_NIB_IDX);
   // Software writes yield to a running instruction
   assign wr_ok = reg_wr && !busy;

   always_comb begin
      x_next = x_reg;
      y_next = y_reg;
      sp_next = sp_reg;
      ccr_next = ccr_reg;
      if (base_step && idx.base_sel == lpea_pkg::BASE_X) begin
         x_next = idx.base_new;
      end
      if (base_step && idx.base_sel == lpea_pkg::BASE_Y) begin
         y_next = idx.base_new;
      end
      if (base_step && idx.base_sel == lpea_pkg::BASE_SP) begin
         sp_next = idx.base_new;
      end
      // Destination wins over a base step on the same register
      if (last && cur_dest == lpea_pkg::DST_X) begin
         x_next = result;
      end
      if (last && cur_dest == lpea_pkg::DST_Y) begin
         y_next = result;
      end
      if (last && cur_dest == lpea_pkg::DST_SP) begin
         sp_next = result;
      end
      if (load_done) begin
         ccr_next[lpea_pkg::CCR_N] = result[15];
         ccr_next[lpea_pkg::CCR_Z] = (result == 16'h0000);
         ccr_next[lpea_pkg::CCR_V] = 1'b0;
      end
      if (wr_ok && reg_addr == lpea_pkg::REG_X) begin
         x_next = reg_wdata;
      end else if (wr_ok && reg_addr == lpea_pkg::REG_Y) begin
         y_next = reg_wdata;
      end else if (wr_ok && reg_addr == lpea_pkg::REG_SP) begin
         sp_next = reg_wdata;
      end else if (wr_ok && reg_addr == lpea_pkg::REG_CCR) begin
         ccr_next = reg_wdata[7:0];
      end
   end

   // ****************************************
   // Register read port
   // ****************************************
   always_comb begin
      rdata_next = 16'h0000;
      if (reg_rd && reg_addr == lpea_pkg::REG_X) begin
         rdata_next = x_reg;
      end else if (reg_rd && reg_addr == lpea_pkg::REG_Y) begin
         rdata_next = y_reg;
      end else if (reg_rd && reg_addr == lpea_pkg::REG_SP) begin
         rdata_next = sp_reg;
      end else if (reg_rd && reg_addr == lpea_pkg::REG_CCR) begin
         rdata_next = {8'h00, ccr_reg};
      end else if (reg_rd && reg_addr == lpea_pkg::REG_STATUS) begin
         rdata_next = {13'h0000, cyc_reg[1:0], busy};
      end
   end

   // ****************************************
   // State registers
   // ****************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         ph_reg <= P_IDLE;
         pend_reg <= PD_NONE;
         cyc_reg <= 3'h0;
      end else begin
         ph_reg <= ph_next;
         pend_reg <= pend_next;
         cyc_reg <= accept ? 3'h1 : (busy && !last) ? 3'(cyc_reg + 3'h1) :
                    3'h0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         op_reg <= 8'h00;
         pb_reg <= 8'h00;
         ext_reg <= 16'h0000;
      end else if (accept) begin
         op_reg <= opcode;
         pb_reg <= postbyte;
         ext_reg <= operand;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ptr_reg <= 16'h0000;
         data_reg <= 16'h0000;
         addr_reg <= 16'h0000;
      end else begin
         ptr_reg <= ptr_fwd;
         data_reg <= data_fwd;
         addr_reg <= mem_rd ? mem_addr : addr_reg;
      end
   end

   // CONDITION_CODE_REGISTER moves on pointer loads and software writes, never on address loads
   always_ff @(posedge clock) begin
      if (rst) begin
         x_reg <= lpea_pkg::PTR_RESET;
         y_reg <= lpea_pkg::PTR_RESET;
         sp_reg <= lpea_pkg::PTR_RESET;
         ccr_reg <= lpea_pkg::CCR_RESET;
         rdata_reg <= 16'h0000;
      end else begin
         x_reg <= x_next;
         y_reg <= y_next;
         sp_reg <= sp_next;
         ccr_reg <= ccr_next;
         rdata_reg <= rdata_next;
      end
   end

   assign ptr_x = x_reg;
   assign ptr_y = y_reg;
   assign ptr_sp = sp_reg;
   assign condition_code_register = ccr_reg;
   assign reg_rdata = rdata_reg;

endmodule : lpea_unit
`default_nettype wire

// File: verif/lpea_properties.sv
`timescale 1ns/100ps
`default_nettype none
module lpea_checker (
   input wire logic clock,
   input wire logic rst,
   input wire logic start,
   input wire logic [7:0] opcode,
   input wire logic [7:0] postbyte,
   input wire logic [15:0] operand,
   input wire logic busy,
   input wire logic done,
   input wire logic illegal,
   input wire logic mem_rd,
   input wire logic mem_word,
   input wire logic [15:0] mem_addr,
   input wire logic prog_fetch,
   input wire logic [15:0] prog_addr,
   input wire logic [7:0] condition_code_register
);
   // ********
   // Decode
   // ********
   wire go = start && !busy;
   wire dst = opcode[3:0] >= 4'hd;
   wire lop = opcode[7:2] == 6'h06 && opcode[1:0] != 2'h0;
   wire lea = lop && !illegal;
   wire ix = opcode[7:4] == 4'he && dst && postbyte[7:5] == 3'h7;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   a_done_one_pulse: assert property (done |=> !done)
      else $error("done held");
   a_imm_two_cyc: assert property (go && opcode[7:4] == 4'hc && dst
      |=> !done ##1 done) else $error("immediate load length");
   a_ext_addr_len: assert property (go && opcode[7:4] == 4'hf && dst
      |=> mem_rd && mem_addr == $past(operand) ##2 done)
      else $error("extended load");
   a_idx16_four: assert property (go && ix && postbyte[2:0] == 3'h2
      |=> !done [*3] ##1 done) else $error("16-bit offset length");
   a_ind_six: assert property (go && ix && postbyte[1:0] == 2'h3
      |=> !done [*5] ##1 done) else $error("indirect length");
   a_lea_two_cyc: assert property (go && lea |=> !done ##1 done)
      else $error("ea load length");
   a_lea_flags_kept: assert property (go && lea
      |=> $stable(condition_code_register) [*3]) else $error("flags moved");
   a_lea_no_read: assert property (go && lea |=> !mem_rd [*2])
      else $error("ea load read memory");
   a_short_refetch: assert property (go && lea && !postbyte[5]
      |=> prog_fetch ##1 prog_fetch && $stable(prog_addr))
      else $error("no second fetch");
   a_lea_pc_step: assert property (go && lea && postbyte[5]
      |=> ##1 prog_fetch && prog_addr == 16'($past(prog_addr) + 16'h0002))
      else $error("ea load second fetch address");
   a_lea_ind_refused: assert property (go && lop && postbyte[7:5] == 3'h7
      && postbyte[1:0] == 2'h3 |-> illegal ##1 !busy)
      else $error("indirect ea accepted");
   a_word_aligned: assert property (mem_rd && mem_word |-> !mem_addr[0])
      else $error("odd word access");
endmodule : lpea_checker
`default_nettype wire

// File: verif/lpea_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module lpea_mem_model (
   input wire logic clock,
   input wire logic mem_rd,
   input wire logic mem_word,
   input wire logic [15:0] mem_addr,
   output logic [15:0] mem_rdata
);
   logic hit = 1'b0;
   logic wd = 1'b0;
   logic [15:0] a = 16'h0000;
   logic [15:0] cnt = 16'h0000;
   function automatic logic [7:0] mb(input logic [15:0] x);
      return x[7:0] + x[15:8] + 8'h3c;
   endfunction : mb
   always @(posedge clock) begin
      hit <= mem_rd;
      wd <= mem_word;
      a <= mem_addr;
      cnt <= cnt + 16'h1;
   end
   // Idle cycles show a moving pattern so stale data is never mistaken
   assign mem_rdata = !hit ? cnt ^ 16'ha5c3 : wd ? {mb(a), mb(a + 16'h1)}
      : {cnt[7:0], mb(a)};
endmodule : lpea_mem_model
`default_nettype wire

// File: verif/tb_pointer_load_and_ea_load_unit.sv
`timescale 1ns/100ps
`default_nettype none
module tb_pointer_load_and_ea_load_unit;
   logic clock = 1'b0, rst = 1'b1, start = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] opcode = 8'h00, postbyte = 8'h00, mc, pb;
   logic [15:0] operand = 16'h0000, pc_in = 16'h0000, acc_d = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000, mx, my, ms, v, od;
   logic [2:0] reg_addr = 3'h0;
   logic busy, done, illegal, mem_rd, mem_word, prog_fetch;
   logic [15:0] mem_addr, mem_rdata, prog_addr, reg_rdata, ptr_x, ptr_y, ptr_sp;
   logic [7:0] condition_code_register;
   logic [3:0] hi_t [6] = '{4'hc, 4'hd, 4'hf, 4'he, 4'he, 4'he};
   logic [7:0] pb_t [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'he2, 8'he3};
   logic [2:0] n_t [6] = '{3'h2, 3'h3, 3'h3, 3'h3, 3'h4, 3'h6};
   logic [58:0] q [$];
   int err_total = 0, checks = 0, cyc = 0;
   always #20 clock = ~clock;
   lpea_unit uut (.clock(clock), .rst(rst), .start(start), .opcode(opcode),
      .postbyte(postbyte), .operand(operand), .pc_in(pc_in), .acc_d(acc_d),
      .busy(busy), .done(done), .illegal(illegal), .mem_rd(mem_rd),
      .mem_word(mem_word), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
      .prog_fetch(prog_fetch), .prog_addr(prog_addr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ptr_x(ptr_x), .ptr_y(ptr_y), .ptr_sp(ptr_sp),
      .condition_code_register(condition_code_register));
   lpea_mem_model u_mem (.clock(clock), .mem_rd(mem_rd), .mem_word(mem_word),
      .mem_addr(mem_addr), .mem_rdata(mem_rdata));
   function automatic logic [7:0] mb(input logic [15:0] x);
      return x[7:0] + x[15:8] + 8'h3c;
   endfunction : mb
   function automatic logic [15:0] w(input logic [15:0] x);
      return {mb(x), mb(x + 16'h1)};
   endfunction : w
   task automatic check(input logic [58:0] seen, input logic [58:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : test_done
   task automatic run(input logic [7:0] op, p, input logic [15:0] d,
      input logic [2:0] n, input logic ld);
      int i;
      if (ld) mc = {mc[7:4], v[15], v == 16'h0, 1'b0, mc[0]};
      q.push_back({mx, my, ms, mc, n});
      @(posedge clock);
      start <= 1'b1; opcode <= op; postbyte <= p; operand <= d;
      @(posedge clock);
      start <= 1'b0;
      for (i = 0; i < 20; i++) begin
         @(negedge clock);
         if (done === 1'b1) break;
      end
      if (i == 20) begin
         err_total++;
         test_done();
      end
      @(posedge clock);
   endtask : run
   task automatic bad(input logic [7:0] op, p);
      @(posedge clock);
      start <= 1'b1; opcode <= op; postbyte <= p;
      @(negedge clock);
      check(illegal, 1'b1);
      @(posedge clock);
      start <= 1'b0;
      @(negedge clock);
      check(busy, 1'b0);
   endtask : bad
   task automatic wr(input logic [2:0] ad, input logic [15:0] d);
      @(posedge clock);
      reg_wr <= 1'b1; reg_addr <= ad; reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] ad, input logic [15:0] e);
      @(posedge clock);
      reg_rd <= 1'b1; reg_addr <= ad;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      check(reg_rdata, e);
   endtask : rd
   // ********
   // Result watcher
   // ********
   always @(negedge clock) begin
      if (busy === 1'b1) cyc++;
      if (done === 1'b1) begin
         @(negedge clock);
         if (q.size() == 0) check(1'b0, 1'b1);
         else check({ptr_x, ptr_y, ptr_sp, condition_code_register,
            cyc[2:0]}, q.pop_front());
         cyc = 0;
      end
   end
   initial begin
      void'($urandom(32'h79845493));
      pc_in = $urandom;
      acc_d = $urandom;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      check({ptr_x, ptr_y, ptr_sp, condition_code_register},
         {48'h0, lpea_pkg::CCR_RESET});
      mx = $urandom; my = $urandom; ms = $urandom; mc = $urandom;
      wr(lpea_pkg::REG_X, mx); wr(lpea_pkg::REG_Y, my);
      wr(lpea_pkg::REG_SP, ms); wr(lpea_pkg::REG_CCR, {8'h00, mc});
      rd(lpea_pkg::REG_CCR, {8'h00, mc});
      rd(3'h5, 16'h0000);
      rd(lpea_pkg::REG_STATUS, 16'h0000);
      $display("register port done");
      for (int d = 13; d < 16; d++)
         for (int j = 0; j < 6; j++) begin
            od = $urandom;
            case (j)
               0: v = od;
               1: v = w({8'h00, od[7:0]});
               2: v = w(od);
               3: v = w(mx);
               4: v = w(mx + od);
               default: v = w(w(mx + od));
            endcase
            if (d == 15) ms = v; else if (d == 14) mx = v; else my = v;
            run({hi_t[j], d[3:0]}, pb_t[j], od, n_t[j], 1'b1);
         end
      v = 16'h0000; mx = v; run(8'hce, 8'h00, v, 3'h2, 1'b1);
      $display("pointer loads done");
      ms = mx; run(8'h1b, 8'h00, 16'h0, 3'h2, 1'b0);
      mx = my; my = my + 16'h4; run(8'h1a, 8'h73, 16'h0, 3'h2, 1'b0);
      my = ms - 16'h10; run(8'h19, 8'hf1, 16'h00f0, 3'h2, 1'b0);
      mx = my + acc_d; run(8'h1a, 8'hee, 16'h0, 3'h2, 1'b0);
      ms = ms - 16'h2; run(8'h1b, 8'hae, 16'h0, 3'h2, 1'b0);
      run(8'h1b, 8'hb1, 16'h0, 3'h2, 1'b0);
      od = $urandom; mx = mx + od; run(8'h1a, 8'he2, od, 3'h2, 1'b0);
      bad(8'h1b, 8'he3);
      bad(8'h00, 8'h00);
      $display("effective address loads done");
      test_done();
   end
endmodule : tb_pointer_load_and_ea_load_unit
bind lpea_unit lpea_checker u_chk (.clock(clock), .rst(rst), .start(start),
   .opcode(opcode), .postbyte(postbyte), .operand(operand), .busy(busy),
   .done(done), .illegal(illegal), .mem_rd(mem_rd), .mem_word(mem_word),
   .mem_addr(mem_addr), .prog_fetch(prog_fetch), .prog_addr(prog_addr),
   .condition_code_register(condition_code_register));
`default_nettype wire
